// File: logic/acr_control.sv
// acr_control: control, prescaler, successive approximation sequencing and result registers
// assumes the analog front end runs on clk and answers dac_code through cmp_above
`timescale 1ns/1ps
module acr_control
	import acr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire acr_bus_req_t bus_req,
	output logic [7:0] rd_data,
	input wire logic global_irq_enable,
	input wire logic irq_vector_taken,
	input wire logic trigger_in,
	input wire logic free_run_mode,
	input wire logic cmp_above,
	output acr_front_t front,
	output logic irq
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [6:0] div_mask(input logic [2:0] sel);
		case (sel)
			3'd0, 3'd1: div_mask = 7'h01;
			3'd2: div_mask = 7'h03;
			3'd3: div_mask = 7'h07;
			3'd4: div_mask = 7'h0f;
			3'd5: div_mask = 7'h1f;
			3'd6: div_mask = 7'h3f;
			default: div_mask = 7'h7f;
		endcase
	endfunction : div_mask

	function automatic logic [15:0] present(input logic [9:0] res, input logic left);
		if (left) begin
			present = {res, 6'h00};
		end else begin
			present = {6'h00, res};
		end
	endfunction : present

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic reference_select_reg;
	logic left_align_reg;
	logic [1:0] channel_select_reg;
	logic converter_enable_reg;
	logic auto_trigger_enable_reg;
	logic conversion_done_flag_reg;
	logic conversion_irq_enable_reg;
	logic [2:0] clock_divider_select_reg;
	logic [9:0] result_reg;
	logic read_lock_reg;
	logic [6:0] prescale_reg;
	logic trigger_prev_reg;
	logic first_pending_reg;
	acr_state_t state_reg;
	logic [4:0] cycle_reg;
	logic [4:0] length_reg;
	logic [4:0] sample_cycle_reg;
	logic [9:0] sar_reg;
	logic [3:0] bit_idx_reg;
	logic active_reference_reg;
	logic [1:0] active_channel_reg;
	logic [7:0] rd_data_reg;
	acr_front_t front_reg;
	logic irq_reg;

	logic wr_input_select;
	logic wr_control;
	logic start_written;
	logic trigger_edge;
	logic prescale_tick;
	logic conv_last;
	logic conv_done;
	logic start_request;
	logic trigger_accept;
	logic rd_result_low;
	logic rd_result_high;
	logic [15:0] presented;

	assign wr_input_select = bus_req.wr && (bus_req.addr == ACR_OFF_INPUT_SELECT);
	assign wr_control = bus_req.wr && (bus_req.addr == ACR_OFF_CONTROL_STATUS_A);
	assign start_written = wr_control && bus_req.wdata[ACR_BIT_START]
		&& bus_req.wdata[ACR_BIT_ENABLE];
	assign trigger_edge = converter_enable_reg && auto_trigger_enable_reg && !free_run_mode
		&& trigger_in && !trigger_prev_reg;
	assign prescale_tick = converter_enable_reg
		&& ((prescale_reg & div_mask(clock_divider_select_reg))
		== div_mask(clock_divider_select_reg));
	assign conv_last = (state_reg == ACR_CONVERT) && (cycle_reg == length_reg - 5'd1);
	assign conv_done = conv_last && prescale_tick;
	assign start_request = start_written || trigger_edge;
	assign presented = present(result_reg, left_align_reg);

	// a trigger ignored while busy must not shift the converter clock phase
	assign trigger_accept = trigger_edge && (state_reg == ACR_IDLE);
	assign rd_result_low = bus_req.rd && (bus_req.addr == ACR_OFF_RESULT_LOW);
	assign rd_result_high = bus_req.rd && (bus_req.addr == ACR_OFF_RESULT_HIGH);

	// ----------------------------------------------------------------
	// input select register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reference_select_reg <= 1'b0;
			left_align_reg <= 1'b0;
			channel_select_reg <= 2'b00;
		end else if (wr_input_select) begin
			reference_select_reg <= bus_req.wdata[ACR_BIT_REFERENCE_SELECT];
			left_align_reg <= bus_req.wdata[ACR_BIT_LEFT_ALIGN];
			channel_select_reg <= bus_req.wdata[1:0];
		end
	end

	// selection reaches the front end except while a conversion holds it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			active_reference_reg <= 1'b0;
			active_channel_reg <= 2'b00;
		end else if (state_reg != ACR_CONVERT || conv_last) begin
			active_reference_reg <= reference_select_reg;
			active_channel_reg <= channel_select_reg;
		end
	end

	// ----------------------------------------------------------------
	// control and status register a
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			converter_enable_reg <= 1'b0;
			auto_trigger_enable_reg <= 1'b0;
			conversion_irq_enable_reg <= 1'b0;
			clock_divider_select_reg <= 3'b000;
		end else if (wr_control) begin
			converter_enable_reg <= bus_req.wdata[ACR_BIT_ENABLE];
			auto_trigger_enable_reg <= bus_req.wdata[ACR_BIT_AUTO_TRIGGER];
			conversion_irq_enable_reg <= bus_req.wdata[ACR_BIT_IRQ_ENABLE];
			clock_divider_select_reg <= bus_req.wdata[2:0];
		end
	end

	// set wins over either clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			conversion_done_flag_reg <= 1'b0;
		end else if (conv_done) begin
			conversion_done_flag_reg <= 1'b1;
		end else if (irq_vector_taken
			|| (wr_control && bus_req.wdata[ACR_BIT_DONE_FLAG])) begin
			conversion_done_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= conversion_done_flag_reg && conversion_irq_enable_reg
				&& global_irq_enable;
		end
	end

	// ----------------------------------------------------------------
	// prescaler and trigger edge
	// ----------------------------------------------------------------
	// counter restarts on enable and on an accepted trigger
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prescale_reg <= ACR_RESET_PRESCALE;
		end else if (!converter_enable_reg || trigger_accept) begin
			prescale_reg <= ACR_RESET_PRESCALE;
		end else begin
			prescale_reg <= prescale_reg + 7'd1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trigger_prev_reg <= 1'b0;
		end else begin
			trigger_prev_reg <= trigger_in;
		end
	end

	// first conversion after enabling needs initialisation
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			first_pending_reg <= 1'b1;
		end else if (!converter_enable_reg) begin
			first_pending_reg <= 1'b1;
		end else if (state_reg == ACR_WAIT_EDGE && prescale_tick) begin
			first_pending_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// conversion sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ACR_IDLE;
			cycle_reg <= 5'd0;
			length_reg <= ACR_NORMAL_CYCLES;
			sample_cycle_reg <= ACR_NORMAL_SAMPLE_CYCLE;
		end else if (!converter_enable_reg && !start_written) begin
			state_reg <= ACR_IDLE;
			cycle_reg <= 5'd0;
		end else begin
			case (state_reg)
				ACR_IDLE: begin
					if (start_request) begin
						state_reg <= ACR_WAIT_EDGE;
					end
				end
				ACR_WAIT_EDGE: begin
					if (prescale_tick) begin
						state_reg <= ACR_CONVERT;
						cycle_reg <= 5'd1;
						length_reg <= first_pending_reg ? ACR_FIRST_CYCLES
							: ACR_NORMAL_CYCLES;
						sample_cycle_reg <= first_pending_reg ? ACR_FIRST_SAMPLE_CYCLE
							: ACR_NORMAL_SAMPLE_CYCLE;
					end
				end
				ACR_CONVERT: begin
					if (conv_done) begin
						cycle_reg <= 5'd0;
						if (auto_trigger_enable_reg && free_run_mode) begin
							state_reg <= ACR_WAIT_EDGE;
						end else begin
							state_reg <= ACR_IDLE;
						end
					end else if (prescale_tick) begin
						cycle_reg <= cycle_reg + 5'd1;
					end
				end
				default: begin
					state_reg <= ACR_IDLE;
				end
			endcase
		end
	end

	// successive approximation: one bit decided per converter clock after sampling
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sar_reg <= ACR_RESET_RESULT;
			bit_idx_reg <= ACR_RESULT_MSB;
		end else if (state_reg == ACR_CONVERT && prescale_tick) begin
			if (cycle_reg == sample_cycle_reg) begin
				sar_reg <= ACR_SAR_FIRST_TRIAL;
				bit_idx_reg <= ACR_RESULT_MSB;
			end else if (cycle_reg > sample_cycle_reg
				&& cycle_reg <= sample_cycle_reg + 5'd10) begin
				sar_reg[bit_idx_reg] <= cmp_above;
				if (bit_idx_reg != 4'd0) begin
					sar_reg[bit_idx_reg - 4'd1] <= 1'b1;
					bit_idx_reg <= bit_idx_reg - 4'd1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// result registers and read lock
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			result_reg <= ACR_RESET_RESULT;
		end else if (conv_done && !read_lock_reg) begin
			result_reg <= sar_reg;
		end
	end

	// low byte read freezes both bytes until the high byte is read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			read_lock_reg <= 1'b0;
		end else if (rd_result_low) begin
			read_lock_reg <= 1'b1;
		end else if (rd_result_high) begin
			read_lock_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data_reg <= ACR_RESET_BYTE;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				ACR_OFF_INPUT_SELECT: begin
					rd_data_reg <= {1'b0, reference_select_reg, left_align_reg,
						3'b000, channel_select_reg};
				end
				ACR_OFF_CONTROL_STATUS_A: begin
					rd_data_reg <= {converter_enable_reg,
						(state_reg != ACR_IDLE),
						auto_trigger_enable_reg, conversion_done_flag_reg,
						conversion_irq_enable_reg, clock_divider_select_reg};
				end
				ACR_OFF_RESULT_LOW: begin
					rd_data_reg <= presented[7:0];
				end
				ACR_OFF_RESULT_HIGH: begin
					rd_data_reg <= presented[15:8];
				end
				default: begin
					rd_data_reg <= ACR_RESET_BYTE;
				end
			endcase
		end else begin
			rd_data_reg <= ACR_RESET_BYTE;
		end
	end

	// ----------------------------------------------------------------
	// front end drive
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			front_reg <= '0;
		end else begin
			front_reg.conv_clk <= converter_enable_reg
				&& ((prescale_reg & div_mask(clock_divider_select_reg))
				> (div_mask(clock_divider_select_reg) >> 1));
			front_reg.sample_hold <= (state_reg == ACR_CONVERT)
				&& (cycle_reg <= sample_cycle_reg);
			front_reg.reference_select <= active_reference_reg;
			front_reg.channel_select <= active_channel_reg;
			front_reg.dac_code <= sar_reg;
		end
	end

	assign rd_data = rd_data_reg;
	assign front = front_reg;
	assign irq = irq_reg;

endmodule : acr_control

// File: inc/acr_pkg.sv
// acr_pkg: constants and carrier types for the converter control and result registers
// assumes one system clock domain and a same-clock analog front end
package acr_pkg;

	// ----------------------------------------------------------------
	// register map (index on the register port)
	// ----------------------------------------------------------------
	localparam logic [1:0] ACR_OFF_INPUT_SELECT = 2'h0;
	localparam logic [1:0] ACR_OFF_CONTROL_STATUS_A = 2'h1;
	localparam logic [1:0] ACR_OFF_RESULT_LOW = 2'h2;
	localparam logic [1:0] ACR_OFF_RESULT_HIGH = 2'h3;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ACR_BIT_REFERENCE_SELECT = 6;
	localparam int ACR_BIT_LEFT_ALIGN = 5;
	localparam int ACR_BIT_ENABLE = 7;
	localparam int ACR_BIT_START = 6;
	localparam int ACR_BIT_AUTO_TRIGGER = 5;
	localparam int ACR_BIT_DONE_FLAG = 4;
	localparam int ACR_BIT_IRQ_ENABLE = 3;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] ACR_RESET_BYTE = 8'h00;
	localparam logic [9:0] ACR_RESET_RESULT = 10'h000;
	localparam logic [9:0] ACR_SAR_FIRST_TRIAL = 10'h200;
	localparam logic [6:0] ACR_RESET_PRESCALE = 7'h00;
	localparam logic [4:0] ACR_FIRST_CYCLES = 5'd25;
	localparam logic [4:0] ACR_NORMAL_CYCLES = 5'd13;
	localparam logic [4:0] ACR_FIRST_SAMPLE_CYCLE = 5'd13;
	localparam logic [4:0] ACR_NORMAL_SAMPLE_CYCLE = 5'd1;
	localparam logic [3:0] ACR_RESULT_MSB = 4'd9;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ACR_IDLE = 2'b00,
		ACR_WAIT_EDGE = 2'b01,
		ACR_CONVERT = 2'b10
	} acr_state_t;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} acr_bus_req_t;

	typedef struct packed {
		logic conv_clk;
		logic sample_hold;
		logic reference_select;
		logic [1:0] channel_select;
		logic [9:0] dac_code;
	} acr_front_t;

endpackage : acr_pkg

// File: test/acr_control_monitor.sv
// acr_control_monitor: port-level assertions for the converter control block
// assumes one clock domain; bound to every acr_control instance
`timescale 1ns/1ps
module acr_control_monitor
	import acr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire acr_bus_req_t bus_req,
	input wire logic [7:0] rd_data,
	input wire logic global_irq_enable,
	input wire logic irq_vector_taken,
	input wire logic trigger_in,
	input wire logic free_run_mode,
	input wire logic cmp_above,
	input wire acr_front_t front,
	input wire logic irq
);
	// ----------------------------------------------------------------
	// shadow of written control bits
	// ----------------------------------------------------------------
	logic en_reg;
	logic ie_reg;
	logic la_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			en_reg <= 1'b0;
			ie_reg <= 1'b0;
		end else if (bus_req.wr && bus_req.addr == ACR_OFF_CONTROL_STATUS_A) begin
			en_reg <= bus_req.wdata[ACR_BIT_ENABLE];
			ie_reg <= bus_req.wdata[ACR_BIT_IRQ_ENABLE];
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			la_reg <= 1'b0;
		end else if (bus_req.wr && bus_req.addr == ACR_OFF_INPUT_SELECT) begin
			la_reg <= bus_req.wdata[ACR_BIT_LEFT_ALIGN];
		end
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence off_s;
		!en_reg [*3];
	endsequence
	sequence hold_s;
		front.sample_hold [*2];
	endsequence
	rd_idle_a: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
		else $error("read data not idle");
	sel_zero_a: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 2'h0
		|-> rd_data[7] == 1'b0 && rd_data[4:2] == 3'b000) else $error("reserved bits set");
	right_high_a: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 2'h3
		&& !$past(la_reg) |-> rd_data[7:2] == 6'h00) else $error("high byte upper bits set");
	left_low_a: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 2'h2
		&& $past(la_reg) |-> rd_data[5:0] == 6'h00) else $error("low byte lower bits set");
	sel_lock_a: assert property (hold_s |-> $stable(front.channel_select)
		&& $stable(front.reference_select)) else $error("selection moved while sampling");
	clk_held_a: assert property (off_s |-> !front.conv_clk)
		else $error("converter clock runs while disabled");
	abort_idle_a: assert property (off_s |-> !front.sample_hold)
		else $error("sampling while disabled");
	irq_gate_a: assert property (irq |-> $past(ie_reg) && $past(global_irq_enable))
		else $error("request without enables");
	clk_fall_a: assert property (front.conv_clk |-> ##[1:200] !front.conv_clk)
		else $error("converter clock stuck high");
	clk_rise_a: assert property (en_reg && !front.conv_clk
		|-> ##[1:200] (front.conv_clk || !en_reg)) else $error("converter clock stuck low");
endmodule : acr_control_monitor

bind acr_control acr_control_monitor u_mon (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
	.rd_data(rd_data), .global_irq_enable(global_irq_enable),
	.irq_vector_taken(irq_vector_taken), .trigger_in(trigger_in),
	.free_run_mode(free_run_mode), .cmp_above(cmp_above), .front(front), .irq(irq));

// File: test/acr_front_model.sv
// acr_front_model: ideal multiplexer, sample-hold and comparator
// assumes one input code per reference and channel, driven by the bench
`timescale 1ns/1ps
module acr_front_model
	import acr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire acr_front_t front,
	input wire logic [9:0] lv [8],
	output logic cmp_above
);
	logic [9:0] held_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			held_reg <= 10'h000;
		end else if (front.sample_hold) begin
			held_reg <= lv[{front.reference_select, front.channel_select}];
		end
	end
	assign cmp_above = held_reg >= front.dac_code;
endmodule : acr_front_model

// File: test/adc_control_result_regs_tb.sv
// adc_control_result_regs_tb: random and corner tests of the converter control block
// assumes the front end model stands for the analog side
`timescale 1ns/1ps
module adc_control_result_regs_tb;
	import acr_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	acr_bus_req_t bus_req = '0;
	logic [7:0] rd_data;
	logic gie = 1'b0;
	logic vec = 1'b0;
	logic trig = 1'b0;
	logic frm = 1'b0;
	logic cmp;
	acr_front_t front;
	logic irq;
	logic [9:0] lv [8];
	logic [15:0] lfsr = 16'hcfa8;
	int errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int dv;
	logic [2:0] ps;
	logic [1:0] ch;
	logic rf, la;
	logic [7:0] v;
	logic [9:0] r, ex;
	acr_control dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
		.global_irq_enable(gie), .irq_vector_taken(vec), .trigger_in(trig),
		.free_run_mode(frm), .cmp_above(cmp), .front(front), .irq(irq));
	acr_front_model fe (.clk(clk), .rst_n(rst_n), .front(front), .lv(lv), .cmp_above(cmp));
	always #12.5 clk = ~clk;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt
	task automatic complete_run();
		if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [7:0] q);
		@(posedge clk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1 q = rd_data;
	endtask : rd
	task automatic res(input logic l, output logic [9:0] q);
		logic [7:0] lo, hi;
		rd(ACR_OFF_RESULT_LOW, lo);
		rd(ACR_OFF_RESULT_HIGH, hi);
		q = l ? {hi, lo[7:6]} : {hi[1:0], lo};
	endtask : res
	task automatic wait_done(input int lo, input int hi);
		int t0;
		logic [7:0] s;
		t0 = cyc;
		s = 8'h00;
		while (!s[4] && cyc - t0 < hi + 8) begin
			rd(ACR_OFF_CONTROL_STATUS_A, s);
			if (!s[4]) chk("busy", 10'h001, 10'(s[6]));
		end
		chk("start", 10'(frm), 10'(s[6]));
		chk("length", 10'h001, 10'(cyc - t0 >= lo && cyc - t0 <= hi));
	endtask : wait_done
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			errors++;
			complete_run();
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		for (int k = 0; k < 8; k++) lv[k] = 10'h000;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 1; a < 4; a++) begin
			rd(2'(a), v);
			chk("reset", 10'h000, 10'(v));
		end
		for (int i = 0; i < 6; i++) begin
			lfsr = nxt(lfsr);
			ps = i == 0 ? 3'd0 : i == 1 ? 3'd7 : lfsr[2:0];
			dv = ps == 3'd0 ? 2 : 1 << ps;
			for (int k = 0; k < 8; k++) begin
				lfsr = nxt(lfsr);
				lv[k] <= i == 0 ? 10'h3ff : i == 1 ? 10'h000 : lfsr[9:0];
			end
			{la, rf, ch} = {lfsr[14:13], lfsr[12:11]};
			gie <= lfsr[15];
			wr(ACR_OFF_INPUT_SELECT, {1'b0, rf, la, 3'b000, ch});
			wr(ACR_OFF_CONTROL_STATUS_A, {5'b11000, ps});
			repeat (2 * dv + 4) @(posedge clk);
			wr(ACR_OFF_INPUT_SELECT, {1'b0, ~rf, la, 3'b000, ~ch});
			// window counts from the selection write, 2 * dv + 6 cycles into the conversion
			wait_done(23 * dv - 6, 23 * dv + 2);
			res(la, r);
			chk("first", lv[{rf, ch}], r);
			wr(ACR_OFF_CONTROL_STATUS_A, {5'b10010, ps});
			rd(ACR_OFF_CONTROL_STATUS_A, v);
			chk("csr", 10'({5'b10000, ps}), 10'(v));
			wr(ACR_OFF_CONTROL_STATUS_A, {5'b11001, ps});
			wait_done(12 * dv, 13 * dv + 5);
			repeat (2) @(posedge clk);
			chk("irq", 10'(gie), 10'(irq));
			vec <= 1'b1;
			@(posedge clk);
			vec <= 1'b0;
			repeat (3) @(posedge clk);
			chk("irq_clr", 10'h000, 10'(irq));
			wr(ACR_OFF_INPUT_SELECT, {1'b0, ~rf, ~la, 3'b000, ~ch});
			res(~la, r);
			ex = lv[{~rf, ~ch}];
			chk("second", ex, r);
			rd(ACR_OFF_RESULT_LOW, v);
			// an unblocked update would now show a different code
			lv[{~rf, ~ch}] <= ~ex;
			wr(ACR_OFF_CONTROL_STATUS_A, {5'b11000, ps});
			wait_done(12 * dv, 13 * dv + 5);
			rd(ACR_OFF_RESULT_HIGH, v);
			chk("locked", 10'(la ? {6'h00, ex[9:8]} : ex[9:2]), 10'(v));
			wr(ACR_OFF_CONTROL_STATUS_A, {5'b11000, ps});
			repeat (4 * dv) @(posedge clk);
			wr(ACR_OFF_CONTROL_STATUS_A, 8'h10);
			rd(ACR_OFF_CONTROL_STATUS_A, v);
			chk("abort", 10'h000, 10'(v));
		end
		wr(ACR_OFF_INPUT_SELECT, 8'hff);
		rd(ACR_OFF_INPUT_SELECT, v);
		chk("reserved", 10'h063, 10'(v));
		wr(ACR_OFF_RESULT_LOW, 8'hff);
		wr(ACR_OFF_RESULT_HIGH, 8'h00);
		res(1'b1, r);
		chk("ro", ex, r);
		wr(ACR_OFF_CONTROL_STATUS_A, 8'ha0);
		@(posedge clk);
		trig <= 1'b1;
		wait_done(48, 55);
		trig <= 1'b0;
		wr(ACR_OFF_CONTROL_STATUS_A, 8'hb0);
		frm <= 1'b1;
		wr(ACR_OFF_CONTROL_STATUS_A, 8'he0);
		wait_done(24, 31);
		wr(ACR_OFF_CONTROL_STATUS_A, 8'hb0);
		wait_done(10, 31);
		frm <= 1'b0;
		wr(ACR_OFF_CONTROL_STATUS_A, 8'h10);
		complete_run();
	end
endmodule : adc_control_result_regs_tb
